// *** gcd_pkg.sv ***
// Constants, codes and carrier types for the bus command decoder
package gcd_pkg;
   // ****************************************************
   // Timing
   // ****************************************************
   localparam int CLK_PERIOD_NS = 4;
   localparam int SETTLE_NS     = 2000;
   localparam int SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETTLE_W      = 9;
   localparam logic [SETTLE_W-1:0] SETTLE_LAST = SETTLE_W'(SETTLE_CYC - 1);

   // ****************************************************
   // Receive buffer shape
   // ****************************************************
   localparam int FIFO_DEPTH = 32;
   localparam int FIFO_WIDTH = 9;

   // ****************************************************
   // Multiline command codes
   // ****************************************************
   localparam logic [6:0] CMD_GTL = 7'h01;
   localparam logic [6:0] CMD_SDC = 7'h04;
   localparam logic [6:0] CMD_GET = 7'h08;
   localparam logic [6:0] CMD_LLO = 7'h11;
   localparam logic [6:0] CMD_DCL = 7'h14;
   localparam logic [6:0] CMD_SPE = 7'h18;
   localparam logic [6:0] CMD_SPD = 7'h19;
   localparam logic [6:0] CMD_UNL = 7'h3f;
   localparam logic [6:0] CMD_UNT = 7'h5f;
   localparam logic [1:0] GRP_CMD    = 2'h0;
   localparam logic [1:0] GRP_LISTEN = 2'h1;
   localparam logic [1:0] GRP_TALK   = 2'h2;
   localparam int RQS_BIT = 6;

   // ****************************************************
   // Types
   // ****************************************************
   typedef struct packed {
      logic [7:0] dio_n;
      logic       eoi_n;
      logic       dav_n;
      logic       nrfd_n;
      logic       ndac_n;
      logic       atn_n;
      logic       ifc_n;
      logic       ren_n;
      logic       srq_n;
   } gcd_bus_t;
   localparam gcd_bus_t BUS_IDLE = 16'hffff;
   localparam gcd_bus_t BUS_ZERO = 16'h0000;

   typedef struct packed {
      logic       eoi;
      logic [7:0] data;
   } gcd_rx_t;

   typedef enum logic [1:0] {AH_READY = 2'b00, AH_TAKE = 2'b01, AH_HOLD = 2'b11} gcd_ah_t;
   typedef enum logic [1:0] {SH_IDLE = 2'b00, SH_SETTLE = 2'b01, SH_VALID = 2'b11,
                             SH_DONE = 2'b10} gcd_sh_t;
   typedef enum logic [3:0] {C_NONE, C_GTL, C_SDC, C_GET, C_LLO, C_DCL, C_SPE, C_SPD,
                             C_UNL, C_UNT, C_MLA, C_MTA, C_OTA} gcd_cmd_t;
endpackage

// *** gcd_decoder.sv ***
// Bus command decoder with acceptor, source handshake and receive buffer
`timescale 1ns/100ps

// ****************************************************
// Receive buffer
// ****************************************************
module gcd_fifo #(
   parameter int W = 9,
   parameter int D = 32
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW:0]  wr_reg;
   logic [AW:0]  rd_reg;

   assign in_ready  = !((wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]));
   assign out_valid = (wr_reg != rd_reg);
   assign out_data  = mem[rd_reg[AW-1:0]];

   always_ff @(posedge clk) begin
      if (in_valid && in_ready) begin
         mem[wr_reg[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wr_reg <= '0;
      end else if (in_valid && in_ready) begin
         wr_reg <= wr_reg + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rd_reg <= '0;
      end else if (out_valid && out_ready) begin
         rd_reg <= rd_reg + 1'b1;
      end
   end
endmodule

// ****************************************************
// Decoder top
// ****************************************************
module gcd_decoder (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire gcd_pkg::gcd_bus_t bus_in,
   output gcd_pkg::gcd_bus_t     bus_out,
   output gcd_pkg::gcd_bus_t     bus_oe_n,
   input  wire logic [4:0]       my_addr,
   input  wire logic             talk_only,
   input  wire logic             local_key,
   input  wire logic [7:0]       status_byte,
   input  wire logic             svc_req,
   input  wire logic [7:0]       tx_data,
   input  wire logic             tx_eoi,
   input  wire logic             tx_valid,
   output logic                  tx_ready,
   output gcd_pkg::gcd_rx_t      rx_data,
   output logic                  rx_valid,
   input  wire logic             rx_ready,
   output logic                  listener,
   output logic                  talker,
   output logic                  remote,
   output logic                  lockout,
   output logic                  spoll_mode,
   output logic                  srq_pending,
   output logic                  dev_clear,
   output logic                  trigger
);
   // ****************************************************
   // Command classifier
   // ****************************************************
   function automatic gcd_pkg::gcd_cmd_t decode(input logic [7:0] b, input logic [4:0] a);
      logic [6:0] c;
      c = b[6:0];
      if (c[6:5] == gcd_pkg::GRP_CMD) begin
         case (c)
            gcd_pkg::CMD_GTL: decode = gcd_pkg::C_GTL;
            gcd_pkg::CMD_SDC: decode = gcd_pkg::C_SDC;
            gcd_pkg::CMD_GET: decode = gcd_pkg::C_GET;
            gcd_pkg::CMD_LLO: decode = gcd_pkg::C_LLO;
            gcd_pkg::CMD_DCL: decode = gcd_pkg::C_DCL;
            gcd_pkg::CMD_SPE: decode = gcd_pkg::C_SPE;
            gcd_pkg::CMD_SPD: decode = gcd_pkg::C_SPD;
            default:          decode = gcd_pkg::C_NONE;
         endcase
      end else if (c[6:5] == gcd_pkg::GRP_LISTEN) begin
         decode = (c == gcd_pkg::CMD_UNL) ? gcd_pkg::C_UNL :
                  (c[4:0] == a) ? gcd_pkg::C_MLA : gcd_pkg::C_NONE;
      end else if (c[6:5] == gcd_pkg::GRP_TALK) begin
         decode = (c == gcd_pkg::CMD_UNT) ? gcd_pkg::C_UNT :
                  (c[4:0] == a) ? gcd_pkg::C_MTA : gcd_pkg::C_OTA;
      end else begin
         decode = gcd_pkg::C_NONE;
      end
   endfunction

   gcd_pkg::gcd_bus_t  s1_reg;
   gcd_pkg::gcd_bus_t  s2_reg;
   logic               key1_reg;
   logic               key2_reg;
   logic               ren_d_reg;
   gcd_pkg::gcd_ah_t   ah_reg;
   gcd_pkg::gcd_sh_t   sh_reg;
   logic [7:0]         byte_reg;
   logic               eoi_take_reg;
   logic               atn_take_reg;
   logic               nrfd_drv_reg;
   logic               ndac_drv_reg;
   logic [7:0]         dio_drv_reg;
   logic               eoi_drv_reg;
   logic               dav_drv_reg;
   logic               stb_reg;
   logic [gcd_pkg::SETTLE_W-1:0] cnt_reg;
   logic               listen_reg;
   logic               talk_reg;
   logic               spoll_reg;
   logic               lockout_reg;
   logic               remote_reg;
   logic               srq_reg;
   logic               clear_reg;
   logic               trig_reg;
   logic               atn;
   logic               ifc;
   logic               ren;
   logic               dav;
   logic               take;
   logic               ah_active;
   logic               sh_active;
   logic               push;
   logic               push_ready;
   logic               stb_done;
   gcd_pkg::gcd_cmd_t  cmd;

   // ****************************************************
   // Pin synchronisers
   // ****************************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         s1_reg <= gcd_pkg::BUS_IDLE;
         s2_reg <= gcd_pkg::BUS_IDLE;
         key1_reg <= 1'b0;
         key2_reg <= 1'b0;
      end else begin
         s1_reg <= bus_in;
         s2_reg <= s1_reg;
         key1_reg <= local_key;
         key2_reg <= key1_reg;
      end
   end

   assign atn = !s2_reg.atn_n;
   assign ifc = !s2_reg.ifc_n;
   assign ren = !s2_reg.ren_n;
   assign dav = !s2_reg.dav_n;

   // ****************************************************
   // Acceptor handshake
   // ****************************************************
   assign ah_active = atn || listen_reg;
   assign take      = (ah_reg == gcd_pkg::AH_TAKE);
   assign push      = take && !atn_take_reg && listen_reg;
   assign cmd       = (take && atn_take_reg) ? decode(byte_reg, my_addr) : gcd_pkg::C_NONE;

   always_ff @(posedge clk) begin
      if (rst || !ah_active) begin
         ah_reg <= gcd_pkg::AH_READY;
         nrfd_drv_reg <= 1'b0;
         ndac_drv_reg <= 1'b0;
         byte_reg <= 8'h00;
         eoi_take_reg <= 1'b0;
         atn_take_reg <= 1'b0;
      end else begin
         case (ah_reg)
            gcd_pkg::AH_READY: begin
               ndac_drv_reg <= 1'b1;
               nrfd_drv_reg <= !atn && !push_ready;
               if (dav && !nrfd_drv_reg) begin
                  byte_reg <= ~s2_reg.dio_n;
                  eoi_take_reg <= !s2_reg.eoi_n;
                  atn_take_reg <= atn;
                  nrfd_drv_reg <= 1'b1;
                  ah_reg <= gcd_pkg::AH_TAKE;
               end
            end
            gcd_pkg::AH_TAKE: begin
               ndac_drv_reg <= 1'b0;
               ah_reg <= gcd_pkg::AH_HOLD;
            end
            gcd_pkg::AH_HOLD: begin
               if (!dav) begin
                  ndac_drv_reg <= 1'b1;
                  ah_reg <= gcd_pkg::AH_READY;
               end
            end
            default: ah_reg <= gcd_pkg::AH_READY;
         endcase
      end
   end

   gcd_fifo #(
      .W (gcd_pkg::FIFO_WIDTH),
      .D (gcd_pkg::FIFO_DEPTH)
   ) u_rx_fifo (
      .clk       (clk),
      .rst       (rst),
      .in_valid  (push),
      .in_ready  (push_ready),
      .in_data   ({eoi_take_reg, byte_reg}),
      .out_valid (rx_valid),
      .out_ready (rx_ready),
      .out_data  (rx_data)
   );

   // ****************************************************
   // Addressing state
   // ****************************************************
   always_ff @(posedge clk) begin
      if (rst || ifc) begin
         listen_reg <= 1'b0;
      end else if (cmd == gcd_pkg::C_MLA) begin
         listen_reg <= 1'b1;
      end else if (cmd == gcd_pkg::C_UNL || cmd == gcd_pkg::C_MTA) begin
         listen_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst || ifc) begin
         talk_reg <= 1'b0;
      end else if (cmd == gcd_pkg::C_MTA) begin
         talk_reg <= 1'b1;
      end else if (cmd == gcd_pkg::C_UNT || cmd == gcd_pkg::C_OTA || cmd == gcd_pkg::C_MLA) begin
         talk_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst || ifc) begin
         spoll_reg <= 1'b0;
      end else if (cmd == gcd_pkg::C_SPE) begin
         spoll_reg <= 1'b1;
      end else if (cmd == gcd_pkg::C_SPD) begin
         spoll_reg <= 1'b0;
      end
   end

   // ****************************************************
   // Remote, local and lockout
   // ****************************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         ren_d_reg <= 1'b0;
      end else begin
         ren_d_reg <= ren;
      end
   end

   always_ff @(posedge clk) begin
      if (rst || !ren) begin
         lockout_reg <= 1'b0;
      end else if (cmd == gcd_pkg::C_LLO) begin
         lockout_reg <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst || !ren) begin
         remote_reg <= 1'b0;
      end else if (cmd == gcd_pkg::C_GTL && listen_reg) begin
         remote_reg <= 1'b0;
      end else if (!ren_d_reg || cmd == gcd_pkg::C_MLA) begin
         remote_reg <= 1'b1;
      end else if (key2_reg && !lockout_reg) begin
         remote_reg <= 1'b0;
      end
   end

   // ****************************************************
   // Clear and trigger pulses
   // ****************************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         clear_reg <= 1'b0;
         trig_reg <= 1'b0;
      end else begin
         clear_reg <= cmd == gcd_pkg::C_DCL || (cmd == gcd_pkg::C_SDC && listen_reg);
         trig_reg <= cmd == gcd_pkg::C_GET && listen_reg;
      end
   end

   // ****************************************************
   // Service request
   // ****************************************************
   assign stb_done = (sh_reg == gcd_pkg::SH_VALID) && s2_reg.ndac_n && stb_reg;

   always_ff @(posedge clk) begin
      if (rst) begin
         srq_reg <= 1'b0;
      end else if (svc_req) begin
         srq_reg <= 1'b1;
      end else if (stb_done) begin
         srq_reg <= 1'b0;
      end
   end

   // ****************************************************
   // Source handshake
   // ****************************************************
   assign sh_active = talker && !atn;
   assign tx_ready  = sh_active && !spoll_reg && (sh_reg == gcd_pkg::SH_IDLE);

   always_ff @(posedge clk) begin
      if (rst || !sh_active) begin
         sh_reg <= gcd_pkg::SH_IDLE;
         dio_drv_reg <= 8'h00;
         eoi_drv_reg <= 1'b0;
         dav_drv_reg <= 1'b0;
         stb_reg <= 1'b0;
         cnt_reg <= '0;
      end else begin
         case (sh_reg)
            gcd_pkg::SH_IDLE: begin
               cnt_reg <= '0;
               if (spoll_reg) begin
                  dio_drv_reg <= status_byte;
                  dio_drv_reg[gcd_pkg::RQS_BIT] <= srq_reg;
                  stb_reg <= 1'b1;
                  sh_reg <= gcd_pkg::SH_SETTLE;
               end else if (tx_valid) begin
                  dio_drv_reg <= tx_data;
                  eoi_drv_reg <= tx_eoi;
                  stb_reg <= 1'b0;
                  sh_reg <= gcd_pkg::SH_SETTLE;
               end
            end
            gcd_pkg::SH_SETTLE: begin
               if (cnt_reg != gcd_pkg::SETTLE_LAST) begin
                  cnt_reg <= cnt_reg + 1'b1;
               end else if (s2_reg.nrfd_n && !s2_reg.ndac_n) begin
                  dav_drv_reg <= 1'b1;
                  sh_reg <= gcd_pkg::SH_VALID;
               end
            end
            gcd_pkg::SH_VALID: begin
               if (s2_reg.ndac_n) begin
                  dav_drv_reg <= 1'b0;
                  dio_drv_reg <= 8'h00;
                  eoi_drv_reg <= 1'b0;
                  sh_reg <= gcd_pkg::SH_DONE;
               end
            end
            gcd_pkg::SH_DONE: sh_reg <= gcd_pkg::SH_IDLE;
            default: sh_reg <= gcd_pkg::SH_IDLE;
         endcase
      end
   end

   // ****************************************************
   // Pin drive and status outputs
   // ****************************************************
   assign bus_out  = gcd_pkg::BUS_ZERO;
   assign bus_oe_n = {~dio_drv_reg, ~eoi_drv_reg, ~dav_drv_reg, ~nrfd_drv_reg, ~ndac_drv_reg,
                      3'h7, ~srq_reg};
   assign listener    = listen_reg;
   assign talker      = talk_reg || talk_only;
   assign remote      = remote_reg;
   assign lockout     = lockout_reg;
   assign spoll_mode  = spoll_reg;
   assign srq_pending = srq_reg;
   assign dev_clear   = clear_reg;
   assign trigger     = trig_reg;

   // ****************************************************
   // Checks
   // ****************************************************
   property p_llo;
      @(posedge clk) disable iff (rst) (cmd == gcd_pkg::C_LLO && ren) |=> lockout_reg;
   endproperty
   a_llo: assert property (p_llo)
      else $error("Lockout not entered");

   property p_dcl;
      @(posedge clk) disable iff (rst) (cmd == gcd_pkg::C_DCL) |=> dev_clear ##1 !dev_clear;
   endproperty
   a_dcl: assert property (p_dcl)
      else $error("Device clear pulse wrong");

   property p_spe;
      @(posedge clk) disable iff (rst) (cmd == gcd_pkg::C_SPE && !ifc) |=> spoll_reg;
   endproperty
   a_spe: assert property (p_spe)
      else $error("Serial poll not entered");

   property p_spd;
      @(posedge clk) disable iff (rst) (cmd == gcd_pkg::C_SPD) |=> !spoll_reg;
   endproperty
   a_spd: assert property (p_spd)
      else $error("Serial poll not left");

   property p_unaddr;
      @(posedge clk) disable iff (rst) (take && atn_take_reg && !listen_reg) |=> !trigger;
   endproperty
   a_unaddr: assert property (p_unaddr)
      else $error("Unaddressed device acted");

   property p_mla;
      @(posedge clk) disable iff (rst) (cmd == gcd_pkg::C_MLA && !ifc) |=> listen_reg && !talk_reg;
   endproperty
   a_mla: assert property (p_mla)
      else $error("Listen address not taken");

   property p_mta;
      @(posedge clk) disable iff (rst) (cmd == gcd_pkg::C_MTA && !ifc) |=> talk_reg && !listen_reg;
   endproperty
   a_mta: assert property (p_mta)
      else $error("Talk address not taken");

   property p_scg;
      @(posedge clk) disable iff (rst) (take && byte_reg[6:5] == 2'h3) |-> cmd == gcd_pkg::C_NONE;
   endproperty
   a_scg: assert property (p_scg)
      else $error("Secondary byte decoded");

   property p_ifc;
      @(posedge clk) disable iff (rst) ifc |=> !listen_reg && !talk_reg && !spoll_reg;
   endproperty
   a_ifc: assert property (p_ifc)
      else $error("Interface clear ignored");

   property p_dav;
      @(posedge clk) disable iff (rst) $rose(dav_drv_reg) |-> $past(s2_reg.nrfd_n) && !$past(s2_reg.ndac_n);
   endproperty
   a_dav: assert property (p_dav)
      else $error("Data valid without ready");

   property p_stb;
      @(posedge clk) disable iff (rst) (stb_done && !svc_req) |=> !srq_reg;
   endproperty
   a_stb: assert property (p_stb)
      else $error("Request not cleared by poll");
endmodule

// *** gcd_ctl_model.sv ***
// Bus controller model: sends commands and data, accepts talker bytes
`timescale 1ns/100ps
module gcd_ctl_model (
   input  wire logic              clk,
   input  wire gcd_pkg::gcd_bus_t bus_out,
   input  wire gcd_pkg::gcd_bus_t bus_oe_n,
   output gcd_pkg::gcd_bus_t      bus_in
);
   gcd_pkg::gcd_bus_t drv = '1;
   int                gap = 1;

   // Open drain: a line is low when any party pulls it, else pulled up
   assign bus_in = drv & (bus_oe_n | bus_out);

   task automatic wait_for(input int sel, output logic ok);
      ok = 1'b0;
      for (int n = 0; n < 1000 && ok !== 1'b1; n++) begin
         @(negedge clk);
         case (sel)
            0: ok = bus_in.nrfd_n & ~bus_in.ndac_n;
            1: ok = bus_in.ndac_n;
            2: ok = ~bus_in.dav_n;
            default: ok = bus_in.dav_n;
         endcase
      end
      @(posedge clk);
   endtask

   task automatic send(input logic [7:0] b, input logic atn, input logic eoi, output logic ok);
      @(posedge clk);
      if (atn && drv.atn_n) begin
         drv.atn_n <= 1'b0;
         repeat (25) @(posedge clk);
      end
      drv.atn_n <= ~atn;
      drv.dio_n <= ~b;
      drv.eoi_n <= ~eoi;
      wait_for(0, ok);
      if (ok) begin
         repeat (gap) @(posedge clk);
         drv.dav_n <= 1'b0;
         wait_for(1, ok);
      end
      drv.dav_n <= 1'b1;
      drv.dio_n <= '1;
      drv.eoi_n <= 1'b1;
   endtask

   task automatic recv(output logic [8:0] b, output logic ok);
      @(posedge clk);
      drv.nrfd_n <= 1'b1;
      drv.ndac_n <= 1'b0;
      wait_for(2, ok);
      b = {~bus_in.eoi_n, ~bus_in.dio_n};
      drv.nrfd_n <= 1'b0;
      repeat (gap) @(posedge clk);
      drv.ndac_n <= 1'b1;
      wait_for(3, ok);
      drv.nrfd_n <= 1'b1;
   endtask
endmodule

// *** gcd_decoder_bench.sv ***
// Self-checking bench for the bus command decoder
`timescale 1ns/100ps
module gcd_decoder_bench;
   // ****************************************************
   // Signals
   // ****************************************************
   logic              clk = 1'b0;
   logic              rst = 1'b1;
   gcd_pkg::gcd_bus_t bus_in, bus_out, bus_oe_n;
   logic [4:0]        my_addr = 5'h10;
   logic              talk_only = 1'b0;
   logic              local_key = 1'b0;
   logic [7:0]        status_byte = 8'h05;
   logic              svc_req = 1'b0;
   logic [7:0]        tx_data = 8'h00;
   logic              tx_eoi = 1'b0;
   logic              tx_valid = 1'b0;
   logic              rx_ready = 1'b0;
   gcd_pkg::gcd_rx_t  rx_data;
   logic              tx_ready, rx_valid, listener, talker, remote, lockout;
   logic              spoll_mode, srq_pending, dev_clear, trigger, ok;
   logic [8:0]        got;
   int                bad_count = 0;
   int                total_checks = 0;
   int                clr_cnt = 0;
   int                trg_cnt = 0;
   // Command byte, then expected {listener, talker, serial poll, lockout}
   localparam logic [11:0] ROWS [13] = '{12'h308, 12'h504, 12'h308, 12'h368, 12'h3f0, 12'h504,
      12'h510, 12'h504, 12'h5f0, 12'h111, 12'h183, 12'h653, 12'h191};

   always #2 clk = ~clk;

   gcd_decoder DUT (.clk, .rst, .bus_in, .bus_out, .bus_oe_n, .my_addr, .talk_only, .local_key,
      .status_byte, .svc_req, .tx_data, .tx_eoi, .tx_valid, .tx_ready, .rx_data, .rx_valid,
      .rx_ready, .listener, .talker, .remote, .lockout, .spoll_mode, .srq_pending, .dev_clear,
      .trigger);
   gcd_ctl_model u_ctl (.clk(clk), .bus_out(bus_out), .bus_oe_n(bus_oe_n), .bus_in(bus_in));

   always @(posedge clk) begin
      if (dev_clear === 1'b1) clr_cnt++;
      if (trigger === 1'b1) trg_cnt++;
   end

   // ****************************************************
   // Checking
   // ****************************************************
   task automatic chk_flag(input logic g, input logic e, input string m);
      total_checks++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value at %0t: %s got %b want %b", $time, m, g, e);
      end
   endtask

   task automatic chk_val(input logic [8:0] g, input logic [8:0] e, input string m);
      total_checks++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value at %0t: %s got %h want %h", $time, m, g, e);
      end
   endtask

   function automatic logic [8:0] st();
      return {4'h0, remote, listener, talker, spoll_mode, lockout};
   endfunction

   task automatic cmd(input logic [7:0] b);
      u_ctl.send(b, 1'b1, 1'b0, ok);
      chk_flag(ok, 1'b1, "command handshake");
      repeat (6) @(posedge clk);
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // ****************************************************
   // Tests
   // ****************************************************
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      chk_val(st(), 9'h000, "reset state");
      chk_flag(&bus_oe_n, 1'b1, "lines released");
      chk_flag(|bus_out, 1'b0, "drive level low");
      chk_flag(tx_ready, 1'b0, "no talker at reset");
      u_ctl.drv.ren_n <= 1'b0;
      repeat (6) @(posedge clk);
      for (int i = 0; i < 13; i++) begin
         cmd(ROWS[i][11:4]);
         chk_val(st(), {4'h1, ROWS[i][3:0]}, "command row");
      end
      $display("command table done");
      local_key <= 1'b1;
      repeat (8) @(posedge clk);
      chk_flag(remote, 1'b1, "key under lockout");
      local_key <= 1'b0;
      cmd(8'h04);
      cmd(8'h08);
      chk_val(9'(clr_cnt + trg_cnt), 9'h000, "unaddressed");
      cmd(8'h14);
      chk_val(9'(clr_cnt), 9'h001, "universal clear");
      cmd(8'h3f);
      cmd(8'h30);
      cmd(8'h04);
      chk_val(9'(clr_cnt), 9'h002, "selective clear");
      cmd(8'h08);
      chk_val(9'(trg_cnt), 9'h001, "trigger");
      cmd(8'h01);
      chk_flag(remote, 1'b0, "go to local");
      $display("addressed commands done");
      for (int i = 0; i < 33; i++) begin
         u_ctl.send(8'h40 + 8'(i), 1'b0, i == 31, ok);
         chk_flag(ok, i < 32, "buffer fill");
      end
      for (int i = 0; i < 32; i++) begin
         @(posedge clk) rx_ready <= 1'b1;
         @(negedge clk);
         chk_flag(rx_valid, 1'b1, "word ready");
         chk_val(rx_data, {i == 31, 8'h40 + 8'(i)}, "buffer word");
         @(posedge clk) rx_ready <= 1'b0;
      end
      @(negedge clk);
      chk_flag(rx_valid, 1'b0, "buffer empty");
      $display("buffer done");
      @(posedge clk) svc_req <= 1'b1;
      @(posedge clk) svc_req <= 1'b0;
      repeat (4) @(posedge clk);
      chk_flag(srq_pending & ~bus_in.srq_n, 1'b1, "service request");
      cmd(8'h50);
      chk_flag(listener, 1'b0, "talk address unlistens");
      u_ctl.gap = 6;
      u_ctl.drv.atn_n <= 1'b1;
      tx_data <= 8'ha5;
      tx_eoi <= 1'b1;
      tx_valid <= 1'b1;
      for (int n = 0; n < 50; n++) begin
         @(negedge clk);
         if (tx_ready === 1'b1) break;
      end
      chk_flag(tx_ready, 1'b1, "talker ready");
      @(posedge clk) tx_valid <= 1'b0;
      u_ctl.recv(got, ok);
      chk_val(got, 9'h1a5, "talker byte");
      cmd(8'h18);
      u_ctl.drv.atn_n <= 1'b1;
      u_ctl.recv(got, ok);
      chk_val(got, 9'h045, "poll status");
      repeat (4) @(posedge clk);
      chk_flag(srq_pending, 1'b0, "request cleared");
      cmd(8'h19);
      $display("talker done");
      cmd(8'h30);
      u_ctl.drv.ifc_n <= 1'b0;
      repeat (10) @(posedge clk);
      u_ctl.drv.ifc_n <= 1'b1;
      repeat (4) @(posedge clk);
      chk_val({7'h0, listener, talker}, 9'h000, "interface clear");
      u_ctl.drv.ren_n <= 1'b1;
      repeat (6) @(posedge clk);
      chk_val({7'h0, remote, lockout}, 9'h000, "remote dropped");
      talk_only <= 1'b1;
      repeat (2) @(posedge clk);
      chk_flag(talker, 1'b1, "talk only");
      talk_only <= 1'b0;
      $display("clear and remote done");
      print_verdict();
   end

   // Whole run takes some 12 us; a hang is cut well after that
   initial begin
      #200000;
      bad_count++;
      $display("wrong value at %0t: run timed out", $time);
      print_verdict();
   end
endmodule
